// ===== src/dam_pkg.sv
// Shared constants, register map and ECC encoder of the diagnostic alarm monitor.
package dam_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int OVL_DEB_US = 20;
  localparam int OVL_DEB_CYC = OVL_DEB_US * CLK_MHZ;
  localparam int OVL_RETRY_US = 40;
  localparam int OVL_RETRY_CYC = OVL_RETRY_US * CLK_MHZ;
  localparam int OSC_GATE_US = 40;
  localparam int OSC_GATE_CYC = OSC_GATE_US * CLK_MHZ;
  localparam int OVL_MAX_CHECKS = 8;
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------
  // Flag positions
  // ----------------------------------------------------------------
  localparam int NUM_FLAGS = 12;
  localparam int F_OVL_TEMP = 0;
  localparam int F_OVL_STAT = 1;
  localparam int F_RX_COIL = 2;
  localparam int F_TX_COIL = 3;
  localparam int F_TEMP = 4;
  localparam int F_AGC = 5;
  localparam int F_SUPPLY = 6;
  localparam int F_DIGITAL = 7;
  localparam int F_BIST = 8;
  localparam int F_ECC_SED = 9;
  localparam int F_ECC_DED = 10;
  localparam int F_OSC = 11;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [5:0] A_STATUS = 6'h00;
  localparam logic [5:0] A_IRQ_EN = 6'h04;
  localparam logic [5:0] A_OSC_MEAS = 6'h08;
  localparam logic [5:0] A_LIM_LO = 6'h0C;
  localparam logic [5:0] A_LIM_HI = 6'h10;
  localparam logic [5:0] A_ECC_INJ = 6'h14;
  localparam logic [5:0] A_OVL_STATE = 6'h18;
  localparam int INJ_HI_LSB = 16;

  // ----------------------------------------------------------------
  // ECC word layout: bit 0 overall parity, bits 1..12 Hamming code
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int CODE_W = 13;
  localparam int SYN_W = 4;

  function automatic logic [CODE_W-1:0] dam_ecc_enc(input logic [DATA_W-1:0] d);
    logic [CODE_W-1:0] c;
    int k;
    c = '0;
    k = 0;
    for (int i = 1; i < CODE_W; i++)
    begin
      if ((i & (i - 1)) != 0)
      begin
        c[i] = d[k];
        k++;
      end
    end
    for (int j = 0; j < SYN_W; j++)
    begin
      for (int i = 1; i < CODE_W; i++)
      begin
        if ((((i >> j) & 1) == 1) && (i != (1 << j)))
        begin
          c[1 << j] = c[1 << j] ^ c[i];
        end
      end
    end
    c[0] = ^c[CODE_W-1:1];
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [NUM_FLAGS-1:0] IRQ_EN_RST = 12'h000;
  localparam logic [CODE_W-1:0] LIM_LO_RST = dam_ecc_enc(8'h00);
  localparam logic [CODE_W-1:0] LIM_HI_RST = dam_ecc_enc(8'hFF);

  typedef enum logic [2:0] {
    OVL_OK = 3'h0,
    OVL_DEB = 3'h1,
    OVL_OFF = 3'h2,
    OVL_CHK = 3'h3,
    OVL_PERM = 3'h4
  } dam_ovl_e;

endpackage

// ===== src/dam_secded_check.sv
// Single-error-correct, double-error-detect checker for one protected word.
`timescale 1ns/10ps
module dam_secded_check
  import dam_pkg::*;
(
  input wire logic [dam_pkg::CODE_W-1:0] code, // Stored code word
  output logic [dam_pkg::DATA_W-1:0] data,     // Corrected data
  output logic sed,                            // Single-bit error seen
  output logic ded                             // Double-bit error seen
);

  logic [SYN_W-1:0] syn;
  logic par;
  logic [CODE_W-1:0] fixed;
  int k;

  always_comb
  begin
    syn = '0;
    fixed = code;
    data = '0;
    k = 0;
    for (int j = 0; j < SYN_W; j++)
    begin
      for (int i = 1; i < CODE_W; i++)
      begin
        if (((i >> j) & 1) == 1)
        begin
          syn[j] = syn[j] ^ code[i];
        end
      end
    end
    par = ^code;
    // A syndrome beyond the last position can only come from several flips.
    sed = par && (syn < 4'(CODE_W));
    ded = (!par && (syn != '0)) || (par && (syn >= 4'(CODE_W)));
    if (sed)
    begin
      fixed[syn] = ~code[syn];
    end
    for (int i = 1; i < CODE_W; i++)
    begin
      if ((i & (i - 1)) != 0)
      begin
        data[k] = fixed[i];
        k++;
      end
    end
  end

endmodule

// ===== src/dam_alarm_monitor.sv
// Diagnostic alarm monitor with overload protection, ECC and oscillator check.
// Operation
// R1: Overcurrent sets flag, debounce then outputs off.
// R2: After retry delay, outputs on and recheck.
// R3: Eight failed checks: outputs off, static flag.
// R4: Permanent shutdown ends by reset or clear.
// R5: Receiver coil faults set temporary flag.
// R6: Transmitter coil fault sets temporary flag.
// R7: Over-temperature sets temporary flag.
// R8: Gain control at limit sets temporary flag.
// R9: Internal supply failure latches static flag.
// R10: Internal digital error latches static flag.
// R11: Self-test checked at start-up only, latched.
// R12: Registers and memory words carry SECDED code; of the registers only lim_lo and lim_hi carry it.
// R13: Any ECC error raises an alarm flag; memory word errors raise one only until the self-test reports done.
// R14: Oscillator frequency measured into readable register.
// R15: Measurement outside host limits sets alarm.
// R16: Static flags hold; temporary ones follow source. The temporary overload flag holds 1 in the off and permanent shutdown states.
// R17: Per-flag enable drives active-low interrupt pin.
// R18: Continuous flags always, start-up flags once.
// R19: Clearing static overload resets retries, outputs on.
`timescale 1ns/10ps
module dam_alarm_monitor
  import dam_pkg::*;
#(
  parameter logic [dam_pkg::CNT_W-1:0] DEB_CYC = 16'(dam_pkg::OVL_DEB_CYC),
  parameter logic [dam_pkg::CNT_W-1:0] RETRY_CYC = 16'(dam_pkg::OVL_RETRY_CYC),
  parameter logic [dam_pkg::CNT_W-1:0] GATE_CYC = 16'(dam_pkg::OSC_GATE_CYC)
)
(
  input wire logic clk_sys,                            // System clock
  input wire logic reset,                              // Power-on reset
  input wire logic [dam_pkg::ADDR_W-1:0] avs_address,  // Byte address
  input wire logic avs_read,                           // Read request
  input wire logic avs_write,                          // Write request
  input wire logic [31:0] avs_writedata,               // Write data
  output logic [31:0] avs_readdata,                    // Read data
  output logic avs_waitrequest,                        // Stall
  input wire logic output_overcurrent_limit,           // Buffer over limit
  input wire logic rx_coil_fault,                      // Receiver coil fault
  input wire logic tx_coil_fault,                      // Transmitter coil fault
  input wire logic temp_fault,                         // Over-temperature
  input wire logic agc_at_limit,                       // Gain at a limit
  input wire logic supply_fault,                       // Internal supply bad
  input wire logic digital_fault,                      // Internal digital error
  input wire logic bist_done,                          // Self-test finished
  input wire logic bist_fail,                          // Self-test result
  input wire logic [dam_pkg::CODE_W-1:0] nvm_word,     // Memory word read
  input wire logic nvm_word_valid,                     // Memory word strobe
  input wire logic tx_osc_in,                          // Oscillator sample
  output logic analog_out_en,                          // Analog outputs on
  output logic alarm_interrupt_pin_n                   // Interrupt, low
);

  typedef struct packed {
    dam_ovl_e ovl_st;
    logic [CNT_W-1:0] cnt;
    logic [3:0] retries;
    logic ana_en;
    logic [NUM_FLAGS-1:0] flags;
    logic [NUM_FLAGS-1:0] irq_en;
    logic [CODE_W-1:0] lim_lo;
    logic [CODE_W-1:0] lim_hi;
    logic [DATA_W-1:0] osc_meas;
    logic meas_valid;
    logic [CNT_W-1:0] gate_cnt;
    logic [DATA_W-1:0] edge_cnt;
    logic osc_prev;
    logic startup_done;
    logic irq_n;
    logic wait_r;
    logic [31:0] rdata;
  } dam_state_s;

  dam_state_s st_r;
  dam_state_s st_nxt;
  logic [CODE_W-1:0] ecc_code [3];
  logic [DATA_W-1:0] ecc_data [3];
  logic [2:0] ecc_sed;
  logic [2:0] ecc_ded;
  logic wr_acc;
  logic clr_ovl;
  logic nvm_chk;
  logic ovl_fail;
  logic [NUM_FLAGS-1:0] f;

  // ----------------------------------------------------------------
  // ECC checkers on stored limits and incoming memory words
  // ----------------------------------------------------------------
  assign ecc_code[0] = st_r.lim_lo;
  assign ecc_code[1] = st_r.lim_hi;
  assign ecc_code[2] = nvm_word;

  genvar g;
  for (g = 0; g < 3; g++)
  begin : g_ecc
    dam_secded_check u_chk (
      .code(ecc_code[g]),
      .data(ecc_data[g]),
      .sed(ecc_sed[g]),
      .ded(ecc_ded[g])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    wr_acc = avs_write && !st_r.wait_r;
    clr_ovl = wr_acc && (avs_address == A_STATUS) && avs_writedata[F_OVL_STAT];
    nvm_chk = nvm_word_valid && !st_r.startup_done;
    ovl_fail = 1'b0;
    f = st_r.flags;

    // Bus slave: one wait cycle, then the access completes.
    st_nxt.wait_r = !((avs_read || avs_write) && st_r.wait_r);
    if (avs_read && st_r.wait_r)
    begin
      st_nxt.rdata = '0;
      unique case (avs_address)
        A_STATUS: st_nxt.rdata[NUM_FLAGS-1:0] = st_r.flags;
        A_IRQ_EN: st_nxt.rdata[NUM_FLAGS-1:0] = st_r.irq_en;
        A_OSC_MEAS: st_nxt.rdata[DATA_W-1:0] = st_r.osc_meas; // R14
        A_LIM_LO: st_nxt.rdata[DATA_W-1:0] = ecc_data[0];
        A_LIM_HI: st_nxt.rdata[DATA_W-1:0] = ecc_data[1];
        A_OVL_STATE: st_nxt.rdata[4:0] = {st_r.ana_en, st_r.retries};
        default: st_nxt.rdata = '0;
      endcase
    end
    if (wr_acc)
    begin
      unique case (avs_address)
        A_IRQ_EN: st_nxt.irq_en = avs_writedata[NUM_FLAGS-1:0];
        A_LIM_LO: st_nxt.lim_lo = dam_ecc_enc(avs_writedata[DATA_W-1:0]); // R12
        A_LIM_HI: st_nxt.lim_hi = dam_ecc_enc(avs_writedata[DATA_W-1:0]); // R12
        A_ECC_INJ:
        begin
          st_nxt.lim_lo = st_r.lim_lo ^ avs_writedata[CODE_W-1:0];
          st_nxt.lim_hi = st_r.lim_hi ^ avs_writedata[INJ_HI_LSB+:CODE_W];
        end
        default: st_nxt.irq_en = st_r.irq_en;
      endcase
    end

    // Continuous temporary flags follow their source.
    f[F_RX_COIL] = rx_coil_fault; // R5
    f[F_TX_COIL] = tx_coil_fault; // R6
    f[F_TEMP] = temp_fault; // R7
    f[F_AGC] = agc_at_limit; // R8
    // Static flags latch until power-on reset.
    f[F_SUPPLY] = st_r.flags[F_SUPPLY] | supply_fault; // R9 R16
    f[F_DIGITAL] = st_r.flags[F_DIGITAL] | digital_fault; // R10 R16
    // Start-up class: sampled once when the self-test reports done.
    if (!st_r.startup_done && bist_done)
    begin
      f[F_BIST] = bist_fail; // R11 R18
      st_nxt.startup_done = 1'b1;
    end
    f[F_ECC_SED] = ecc_sed[0] | ecc_sed[1] | (nvm_chk & ecc_sed[2]); // R13
    f[F_ECC_DED] = st_r.flags[F_ECC_DED] | ecc_ded[0] | ecc_ded[1]
      | (nvm_chk & ecc_ded[2]); // R13 R16

    // Oscillator frequency: rising edges counted over a gate window.
    st_nxt.osc_prev = tx_osc_in;
    if (st_r.gate_cnt == GATE_CYC - 16'h0001)
    begin
      st_nxt.gate_cnt = '0;
      st_nxt.edge_cnt = DATA_W'(tx_osc_in && !st_r.osc_prev);
      st_nxt.osc_meas = st_r.edge_cnt; // R14
      st_nxt.meas_valid = 1'b1;
    end
    else
    begin
      st_nxt.gate_cnt = st_r.gate_cnt + 16'h0001;
      if (tx_osc_in && !st_r.osc_prev && (st_r.edge_cnt != 8'hFF))
      begin
        st_nxt.edge_cnt = st_r.edge_cnt + 8'h01;
      end
    end
    f[F_OSC] = st_r.meas_valid
      && ((st_r.osc_meas < ecc_data[0]) || (st_r.osc_meas > ecc_data[1])); // R15

    // Overload protection sequence.
    unique case (st_r.ovl_st)
      OVL_OK:
      begin
        f[F_OVL_TEMP] = output_overcurrent_limit; // R1
        if (output_overcurrent_limit)
        begin
          st_nxt.ovl_st = OVL_DEB;
          st_nxt.cnt = '0;
        end
      end
      OVL_DEB:
      begin
        f[F_OVL_TEMP] = output_overcurrent_limit; // R16
        if (!output_overcurrent_limit)
        begin
          st_nxt.ovl_st = OVL_OK;
        end
        else if (st_r.cnt == DEB_CYC - 16'h0001)
        begin
          st_nxt.ovl_st = OVL_OFF; // R1
          st_nxt.ana_en = 1'b0;
          st_nxt.cnt = '0;
        end
        else
        begin
          st_nxt.cnt = st_r.cnt + 16'h0001;
        end
      end
      OVL_OFF:
      begin
        if (st_r.cnt == RETRY_CYC - 16'h0001)
        begin
          st_nxt.ovl_st = OVL_CHK; // R2
          st_nxt.ana_en = 1'b1;
          st_nxt.cnt = '0;
        end
        else
        begin
          st_nxt.cnt = st_r.cnt + 16'h0001;
        end
      end
      OVL_CHK:
      begin
        if (!output_overcurrent_limit)
        begin
          st_nxt.ovl_st = OVL_OK; // R2
          st_nxt.retries = '0;
          f[F_OVL_TEMP] = 1'b0;
        end
        else if (st_r.cnt == DEB_CYC - 16'h0001)
        begin
          ovl_fail = 1'b1;
          st_nxt.ana_en = 1'b0;
          st_nxt.cnt = '0;
          st_nxt.retries = st_r.retries + 4'h1;
          st_nxt.ovl_st = OVL_OFF;
          if (st_r.retries == 4'(OVL_MAX_CHECKS - 1))
          begin
            st_nxt.ovl_st = OVL_PERM; // R3
            f[F_OVL_STAT] = 1'b1; // R3
          end
        end
        else
        begin
          st_nxt.cnt = st_r.cnt + 16'h0001;
        end
      end
      OVL_PERM:
      begin
        if (clr_ovl)
        begin
          st_nxt.ovl_st = OVL_OK; // R4 R19
          st_nxt.retries = '0; // R19
          st_nxt.ana_en = 1'b1; // R19
          f[F_OVL_STAT] = 1'b0; // R4
          f[F_OVL_TEMP] = 1'b0;
        end
      end
      default:
      begin
        st_nxt.ovl_st = OVL_OK;
        st_nxt.ana_en = 1'b1;
      end
    endcase

    st_nxt.flags = f;
    st_nxt.irq_n = ~|(f & st_nxt.irq_en); // R17
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      st_r <= '{ovl_st: OVL_OK, cnt: '0, retries: '0, ana_en: 1'b1, flags: '0,
        irq_en: IRQ_EN_RST, lim_lo: LIM_LO_RST, lim_hi: LIM_HI_RST, osc_meas: '0,
        meas_valid: 1'b0, gate_cnt: '0, edge_cnt: '0, osc_prev: 1'b0,
        startup_done: 1'b0, irq_n: 1'b1, wait_r: 1'b1, rdata: '0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata = st_r.rdata;
  assign avs_waitrequest = st_r.wait_r;
  assign analog_out_en = st_r.ana_en;
  assign alarm_interrupt_pin_n = st_r.irq_n;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  sequence s_deb_end;
    st_r.ovl_st == OVL_DEB && output_overcurrent_limit && st_r.cnt == DEB_CYC - 16'h0001;
  endsequence
  sequence s_off_end;
    st_r.ovl_st == OVL_OFF && st_r.cnt == RETRY_CYC - 16'h0001;
  endsequence
  sequence s_last_fail;
    st_r.ovl_st == OVL_CHK && ovl_fail && st_r.retries == 4'(OVL_MAX_CHECKS - 1);
  endsequence
  sequence s_perm_clear;
    st_r.ovl_st == OVL_PERM && clr_ovl;
  endsequence

  property p_r1;
    s_deb_end |=> st_r.ovl_st == OVL_OFF && !analog_out_en ##1 !analog_out_en;
  endproperty
  a_r1: assert property (p_r1) else $error("outputs not off after debounce"); // R1

  property p_r2;
    s_off_end |=> st_r.ovl_st == OVL_CHK && analog_out_en;
  endproperty
  a_r2: assert property (p_r2) else $error("no retry check after delay"); // R2

  property p_r3;
    s_last_fail |=> (st_r.ovl_st == OVL_PERM && st_r.flags[F_OVL_STAT] && !analog_out_en);
  endproperty
  a_r3: assert property (p_r3) else $error("no permanent shutdown"); // R3

  property p_r4;
    st_r.ovl_st == OVL_PERM && !clr_ovl |=> st_r.ovl_st == OVL_PERM && !analog_out_en;
  endproperty
  a_r4: assert property (p_r4) else $error("permanent shutdown left early"); // R4

  property p_r19;
    s_perm_clear |=> st_r.retries == 4'h0 && analog_out_en && !st_r.flags[F_OVL_STAT];
  endproperty
  a_r19: assert property (p_r19) else $error("clear did not restart outputs"); // R19

  property p_r5;
    ##1 st_r.flags[F_RX_COIL] == $past(rx_coil_fault);
  endproperty
  a_r5: assert property (p_r5) else $error("receiver coil flag wrong"); // R5

  property p_r9;
    supply_fault |=> st_r.flags[F_SUPPLY] [*4];
  endproperty
  a_r9: assert property (p_r9) else $error("supply flag not latched"); // R9

  property p_r11;
    st_r.startup_done |=> $stable(st_r.flags[F_BIST]);
  endproperty
  a_r11: assert property (p_r11) else $error("self-test flag changed late"); // R11

  property p_r13;
    (ecc_ded[0] || ecc_ded[1]) |=> st_r.flags[F_ECC_DED];
  endproperty
  a_r13: assert property (p_r13) else $error("ECC double error not flagged"); // R13

  property p_r15;
    st_r.meas_valid && st_r.osc_meas > ecc_data[1] |=> st_r.flags[F_OSC];
  endproperty
  a_r15: assert property (p_r15) else $error("oscillator alarm missing"); // R15

  property p_r17;
    ##1 alarm_interrupt_pin_n == !(|(st_r.flags & st_r.irq_en));
  endproperty
  a_r17: assert property (p_r17) else $error("interrupt pin mismatch"); // R17

endmodule

// ===== bench/dam_host_model.sv
// Host model that reads, programs and clears the alarm block over its register bus.
`timescale 1ns/10ps
module dam_host_model
  import dam_pkg::*;
(
  input wire logic clk_sys,                           // System clock
  output logic [dam_pkg::ADDR_W-1:0] avs_address,     // Byte address
  output logic avs_read,                              // Read request
  output logic avs_write,                             // Write request
  output logic [31:0] avs_writedata,                  // Write data
  input wire logic [31:0] avs_readdata,               // Read data
  input wire logic avs_waitrequest                    // Stall
);
  import dam_pkg::*;

  // ----------------------------------------------------------------
  // Bus access
  // ----------------------------------------------------------------
  int hangs = 0;

  initial
  begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
  end

  // Holds the request until waitrequest is seen low at an edge; limits, enables
  // and the overload clear all go through here.
  task automatic access(input logic rd, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    int k;
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= ~rd;
    avs_writedata <= d;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    if (k >= 50)
    begin
      hangs++;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Released write data is scrambled so that a stale value is never reused.
    avs_writedata <= ~d;
  endtask
endmodule

// ===== bench/tb.sv
// Self-checking testbench of the diagnostic alarm monitor.
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module tb;
  import dam_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic avs_waitrequest;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic [31:0] rdata;
  logic ovc = 1'b0, rx = 1'b0, tx = 1'b0, tmp = 1'b0, agc = 1'b0;
  logic sup = 1'b0, dig = 1'b0, bdone = 1'b0, bfail = 1'b0;
  logic [CODE_W-1:0] nvm = '0;
  logic nvm_v = 1'b0, osc = 1'b0, osc_run = 1'b0, aen, irq_n;
  logic [3:0] osc_div = 4'h0;
  logic [7:0] lim_tab [4][3] = '{'{8'h09, 8'hFF, 8'h01}, '{8'h08, 8'hFF, 8'h00},
                                 '{8'h00, 8'h07, 8'h01}, '{8'h00, 8'h08, 8'h00}};
  int errors = 0;
  int num_checks = 0;

  always #5 clk_sys = ~clk_sys;

  // Oscillator with one rising edge every eight clocks.
  always @(posedge clk_sys)
  begin
    osc_div <= osc_div + 4'h1;
    osc <= osc_run & osc_div[2];
  end

  dam_host_model host_u (.clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  dam_alarm_monitor #(.DEB_CYC(16'h0008), .RETRY_CYC(16'h0010), .GATE_CYC(16'h0040)) dut_u (
    .clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .output_overcurrent_limit(ovc), .rx_coil_fault(rx),
    .tx_coil_fault(tx), .temp_fault(tmp), .agc_at_limit(agc), .supply_fault(sup),
    .digital_fault(dig), .bist_done(bdone), .bist_fail(bfail), .nvm_word(nvm),
    .nvm_word_valid(nvm_v), .tx_osc_in(osc), .analog_out_en(aen),
    .alarm_interrupt_pin_n(irq_n));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    host_u.access(1'b1, a, 32'h0, rdata);
    if (host_u.hangs != 0)
    begin
      errors++;
      close_out();
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    host_u.access(1'b0, a, d, q);
    if (host_u.hangs != 0)
    begin
      errors++;
      close_out();
    end
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    reset <= 1'b1;
    {ovc, rx, tx, tmp, agc, sup, dig, bdone, bfail, nvm_v, osc_run} <= '0;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
  endtask

  task automatic wait_aen(input logic v, input int lim);
    int k;
    k = 0;
    while (aen !== v && k < lim)
    begin
      @(posedge clk_sys);
      k++;
    end
    if (aen !== v)
    begin
      errors++;
      $display("ERROR analog_out_en expected %0h seen %0h", v, aen);
      close_out();
    end
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    do_reset();
    rd(A_STATUS); `CHK("status", 32'h0, rdata)
    rd(A_IRQ_EN); `CHK("irq_en", 32'h0, rdata)
    rd(A_LIM_LO); `CHK("lim_lo", 32'h0, rdata)
    rd(A_LIM_HI); `CHK("lim_hi", 32'hFF, rdata)
    rd(6'h3C); `CHK("unmapped", 32'h0, rdata)
    `CHK("irq_n", 1'b1, irq_n)
    @(posedge clk_sys);
    nvm <= 13'h0006;
    nvm_v <= 1'b1;
    @(posedge clk_sys);
    nvm_v <= 1'b0;
    bdone <= 1'b1;
    bfail <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(A_STATUS); `CHK("startup", 12'h500, rdata[11:0])
    for (int i = 0; i < 4; i++)
    begin
      {agc, tmp, tx, rx} <= 4'h1 << i;
      repeat (3) @(posedge clk_sys);
      rd(A_STATUS); `CHK("temp set", 12'h500 | (12'h004 << i), rdata[11:0])
      {agc, tmp, tx, rx} <= 4'h0;
      repeat (3) @(posedge clk_sys);
      rd(A_STATUS); `CHK("temp clear", 12'h500, rdata[11:0])
    end
    sup <= 1'b1;
    dig <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sup <= 1'b0;
    dig <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd(A_STATUS); `CHK("static", 12'h5C0, rdata[11:0])
    wr(A_IRQ_EN, 32'h4);
    rd(A_IRQ_EN); `CHK("irq_en", 32'h4, rdata)
    `CHK("irq idle", 1'b1, irq_n)
    rx <= 1'b1;
    repeat (3) @(posedge clk_sys);
    `CHK("irq on", 1'b0, irq_n)
    wr(A_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk_sys);
    `CHK("irq masked", 1'b1, irq_n)
    rx <= 1'b0;

    do_reset();
    @(posedge clk_sys);
    bdone <= 1'b1;
    repeat (2) @(posedge clk_sys);
    bfail <= 1'b1;
    nvm_v <= 1'b1;
    @(posedge clk_sys);
    nvm_v <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd(A_STATUS); `CHK("after startup", 12'h000, rdata[11:0])
    wr(A_ECC_INJ, 32'h8);
    rd(A_LIM_LO); `CHK("lim_lo corrected", 32'h0, rdata)
    rd(A_STATUS); `CHK("ecc single", 12'h200, rdata[11:0])
    wr(A_ECC_INJ, 32'h0006_0000);
    rd(A_STATUS); `CHK("ecc double", 2'b11, rdata[10:9])
    osc_run <= 1'b1;
    wr(A_LIM_LO, 32'h0);
    wr(A_LIM_HI, 32'hFF);
    rd(A_STATUS); `CHK("ecc single gone", 2'b10, rdata[10:9])
    repeat (140) @(posedge clk_sys);
    rd(A_OSC_MEAS); `CHK("osc meas", 32'h8, rdata)
    for (int i = 0; i < 4; i++)
    begin
      wr(A_LIM_LO, {24'h0, lim_tab[i][0]});
      wr(A_LIM_HI, {24'h0, lim_tab[i][1]});
      repeat (140) @(posedge clk_sys);
      rd(A_STATUS); `CHK("osc alarm", lim_tab[i][2][0], rdata[F_OSC])
    end

    do_reset();
    @(posedge clk_sys);
    ovc <= 1'b1;
    wait_aen(1'b0, 40);
    rd(A_STATUS); `CHK("ovl temp", 2'b01, rdata[1:0])
    wait_aen(1'b1, 40);
    ovc <= 1'b0;
    repeat (12) @(posedge clk_sys);
    rd(A_OVL_STATE); `CHK("check passed", 32'h10, rdata)
    ovc <= 1'b1;
    wait_aen(1'b0, 40);
    for (int i = 0; i < 8; i++)
    begin
      wait_aen(1'b1, 60);
      wait_aen(1'b0, 60);
    end
    repeat (100) @(posedge clk_sys);
    `CHK("perm off", 1'b0, aen)
    rd(A_STATUS); `CHK("ovl static", 2'b11, rdata[1:0])
    ovc <= 1'b0;
    wr(A_STATUS, 32'h2);
    @(posedge clk_sys);
    `CHK("outputs back", 1'b1, aen)
    rd(A_OVL_STATE); `CHK("retries cleared", 32'h10, rdata)
    rd(A_STATUS); `CHK("ovl cleared", 2'b00, rdata[1:0])
    close_out();
  end
endmodule
